/* dv/cio_far_model.sv */
// Remote fabric node model: takes outbound messages with random stalls
`timescale 1ns/10ps
module cio_far_model (
	// Clock
	input wire logic ref_clk_i,
	// Fabric side
	input wire logic out_valid_i,
	output logic out_ready_o
);
	integer seed = 32'h753a_b789;
	initial begin
		out_ready_o = 1'b0;
		forever begin
			@(posedge ref_clk_i);
			#2 out_ready_o = ($random(seed) % 3) != 0;
		end
	end
endmodule

/* dv/tb_coherent_io_read_home_responder.sv */
// Self-checking bench for the coherent I/O read responder
`timescale 1ns/10ps
module tb_coherent_io_read_home_responder;
	typedef struct packed {
		logic [2:0] kind;
		logic [7:0] dest, sec;
		logic data;
	} msg_t;
	logic ref_clk_i = 1'b0, rst_b_i = 1'b0, req_valid_i = 1'b0, req_collide_i = 1'b0;
	logic rsp_valid_i = 1'b0, cache_rsp_valid_i = 1'b0, push_done_i = 1'b0, out_ready_i;
	logic err_clear_i = 1'b0;
	logic [1:0] req_type_i = '0, cache_rsp_i = '0;
	logic [2:0] dir_state_i = '0, rsp_type_i = '0, out_type_o, err_cause_o;
	logic [7:0] req_src_i = '0, req_sec_i = '0, owner_node_id_i = '0, rsp_src_i = '0;
	logic [7:0] out_dest_o, out_sec_o, err_id_o, s, o, q;
	logic req_ready_o, collide_o, cache_req_o, mem_write_o, out_valid_o, out_data_o, err_o;
	integer seed = 32'h753a_b789;
	int err_count = 0, num_checks = 0;
	msg_t exp_q[$], got, e;

	coherent_io_read_home_responder #(.ID_W(8)) u_dut (.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i), .req_valid_i(req_valid_i), .req_type_i(req_type_i),
		.req_src_i(req_src_i), .req_sec_i(req_sec_i), .req_collide_i(req_collide_i),
		.req_ready_o(req_ready_o), .collide_o(collide_o), .dir_state_i(dir_state_i),
		.owner_node_id_i(owner_node_id_i), .rsp_valid_i(rsp_valid_i),
		.rsp_type_i(rsp_type_i), .rsp_src_i(rsp_src_i), .cache_req_o(cache_req_o),
		.cache_rsp_valid_i(cache_rsp_valid_i), .cache_rsp_i(cache_rsp_i),
		.push_done_i(push_done_i), .mem_write_o(mem_write_o), .out_valid_o(out_valid_o),
		.out_ready_i(out_ready_i), .out_type_o(out_type_o), .out_dest_o(out_dest_o),
		.out_sec_o(out_sec_o), .out_data_o(out_data_o), .orig_req_i(1'b0),
		.orig_home_i(8'h00), .orig_done_o(), .err_clear_i(err_clear_i), .err_o(err_o),
		.err_id_o(err_id_o), .err_cause_o(err_cause_o));

	cio_far_model u_far (.ref_clk_i(ref_clk_i), .out_valid_i(out_valid_o),
		.out_ready_o(out_ready_i));

	initial begin
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	// ------------------------------------------------------------
	// Checking helpers
	// ------------------------------------------------------------
	task automatic cmp(logic [31:0] g, logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, x);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic expect_msg(logic [2:0] k, logic [7:0] d, logic [7:0] x, logic dt);
		exp_q.push_back('{k, d, x, dt});
	endtask

	// Message taken at the coming edge
	always @(negedge ref_clk_i) begin
		if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
			got = '{out_type_o, out_dest_o, out_sec_o, out_data_o};
			// Message with no note queued is a mismatch
			e = ~got;
			if (exp_q.size() != 0) begin
				e = exp_q.pop_front();
			end
			if (e.kind != cio_pkg::MSG_FETCH_FROM_OWNER) begin
				got.sec = e.sec;
			end
			cmp(got, e);
		end
	end

	// ------------------------------------------------------------
	// Drivers
	// ------------------------------------------------------------
	task automatic tick(int n = 1);
		repeat (n) @(posedge ref_clk_i);
		#2;
	endtask

	task automatic send_req(logic [1:0] t, logic [7:0] src, logic [7:0] sec, logic c);
		int n;
		for (n = 0; n < 200 && req_ready_o !== 1'b1; n++) tick();
		if (n == 200) begin
			cmp(0, 1);
			finish_test();
		end
		req_valid_i = 1'b1;
		req_type_i = t;
		req_src_i = src;
		req_sec_i = sec;
		req_collide_i = c;
		tick();
		req_valid_i = 1'b0;
		req_collide_i = 1'b0;
	endtask

	// Wait for cache request, memory write, collision or error
	task automatic wait_out(int w);
		int n;
		for (n = 0; n < 100; n++) begin
			if ((w == 0 && cache_req_o === 1'b1) || (w == 1 && mem_write_o === 1'b1) ||
				(w == 2 && collide_o === 1'b1) || (w == 3 && err_o === 1'b1)) break;
			tick();
		end
		cmp(n < 100, 1);
		if (n == 100) begin
			finish_test();
		end
	endtask

	task automatic drain();
		int n;
		for (n = 0; n < 300 && exp_q.size() != 0; n++) tick();
		if (n == 300) begin
			cmp(0, 1);
			finish_test();
		end
		tick(2);
	endtask

	task automatic rsp(logic [2:0] k, logic [7:0] src);
		rsp_valid_i = 1'b1;
		rsp_type_i = k;
		rsp_src_i = src;
		tick();
		rsp_valid_i = 1'b0;
	endtask

	task automatic crsp(logic [1:0] k);
		cache_rsp_valid_i = 1'b1;
		cache_rsp_i = k;
		tick();
		cache_rsp_valid_i = 1'b0;
	endtask

	task automatic push();
		push_done_i = 1'b1;
		tick();
		push_done_i = 1'b0;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge ref_clk_i);
		#2 rst_b_i = 1'b1;
		tick();
		for (int i = 0; i < 2; i++) begin
			s = 8'($random(seed));
			dir_state_i = (i == 0) ? cio_pkg::DIR_CLEAN_HOME : cio_pkg::DIR_REMOTE_SHARED;
			expect_msg(cio_pkg::MSG_DONE, s, 8'h00, 1'b1);
			send_req(cio_pkg::REQ_FETCH_TO_HOME, s, 8'h00, 1'b0);
			drain();
		end
		s = 8'($random(seed));
		dir_state_i = cio_pkg::DIR_DIRTY_HOME;
		send_req(cio_pkg::REQ_FETCH_TO_HOME, s, 8'h00, 1'b0);
		wait_out(0);
		tick(3);
		cmp(out_valid_o, 0);
		expect_msg(cio_pkg::MSG_DONE, s, 8'h00, 1'b1);
		push();
		drain();
		o = s ^ 8'h5a;
		owner_node_id_i = o;
		dir_state_i = cio_pkg::DIR_DIRTY_REMOTE;
		expect_msg(cio_pkg::MSG_FETCH_FROM_OWNER, o, s, 1'b0);
		send_req(cio_pkg::REQ_FETCH_TO_HOME, s, 8'h00, 1'b0);
		drain();
		expect_msg(cio_pkg::MSG_COMPLETION_3P, s, 8'h00, 1'b0);
		rsp(cio_pkg::MSG_OWNER_SUPPLIED, o);
		wait_out(1);
		drain();
		expect_msg(cio_pkg::MSG_FETCH_FROM_OWNER, o, s, 1'b0);
		send_req(cio_pkg::REQ_FETCH_TO_HOME, s, 8'h00, 1'b0);
		drain();
		expect_msg(cio_pkg::MSG_FETCH_FROM_OWNER, o ^ 8'h02, s, 1'b0);
		rsp(cio_pkg::MSG_RETRY, o ^ 8'h02);
		drain();
		dir_state_i = cio_pkg::DIR_CLEAN_HOME;
		expect_msg(cio_pkg::MSG_PAYLOAD_ONLY, s, 8'h00, 1'b1);
		expect_msg(cio_pkg::MSG_COMPLETION_3P, s, 8'h00, 1'b0);
		rsp(cio_pkg::MSG_OWNERSHIP_ABSENT, o ^ 8'h02);
		drain();
		for (int i = 0; i < 2; i++) begin
			s = 8'($random(seed));
			q = (i == 0) ? s : s ^ 8'h10;
			send_req(cio_pkg::REQ_FETCH_FROM_OWNER, s, q, 1'b0);
			wait_out(0);
			crsp(cio_pkg::CRSP_NOT_READY);
			wait_out(0);
			tick();
			crsp(cio_pkg::CRSP_MODIFIED);
			tick(3);
			cmp(out_valid_o, 0);
			if (i == 1) expect_msg(cio_pkg::MSG_PAYLOAD_ONLY, q, 8'h00, 1'b1);
			expect_msg(cio_pkg::MSG_OWNER_SUPPLIED, s, 8'h00, i == 0);
			push();
			drain();
		end
		send_req(cio_pkg::REQ_FETCH_FROM_OWNER, s, s ^ 8'h03, 1'b0);
		wait_out(0);
		expect_msg(cio_pkg::MSG_OWNERSHIP_ABSENT, s, 8'h00, 1'b0);
		crsp(cio_pkg::CRSP_INVALID);
		drain();
		send_req(cio_pkg::REQ_FETCH_TO_HOME, s, 8'h00, 1'b1);
		wait_out(2);
		tick(3);
		cmp(out_valid_o, 0);
		cmp(err_o, 0);
		dir_state_i = 3'h5;
		send_req(cio_pkg::REQ_FETCH_TO_HOME, s, 8'h00, 1'b0);
		wait_out(3);
		tick(4);
		cmp({err_o, err_cause_o, err_id_o}, {1'b1, cio_pkg::ERR_DIR, s});
		err_clear_i = 1'b1;
		tick();
		err_clear_i = 1'b0;
		cmp(err_o, 0);
		finish_test();
	end
endmodule

/* src/cio_err_latch.sv */
// Sticky protocol error flag with first-offender capture
`timescale 1ns/10ps
module cio_err_latch #(
	parameter int ID_W = 8
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Error event
	input wire logic set_i,
	input wire logic [ID_W-1:0] id_i,
	input wire logic [cio_pkg::ERR_W-1:0] cause_i,
	input wire logic clear_i,
	// Recorded state
	output logic flag_o,
	output logic [ID_W-1:0] id_o,
	output logic [cio_pkg::ERR_W-1:0] cause_o
);

	logic flag_next;
	logic [ID_W-1:0] id_next;
	logic [cio_pkg::ERR_W-1:0] cause_next;

	always_comb begin
		flag_next = flag_o;
		id_next = id_o;
		cause_next = cause_o;
		if (clear_i) begin
			flag_next = 1'b0;
		end
		// Set wins over clear; first error is kept
		if (set_i && (!flag_o || clear_i)) begin
			flag_next = 1'b1;
			id_next = id_i;
			cause_next = cause_i;
		end else if (set_i) begin
			flag_next = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			flag_o <= 1'b0;
			id_o <= '0;
			cause_o <= cio_pkg::ERR_NONE;
		end else begin
			flag_o <= flag_next;
			id_o <= id_next;
			cause_o <= cause_next;
		end
	end

endmodule

/* src/cio_out_msg.sv */
// Outbound message holding register with valid/ready
`timescale 1ns/10ps
module cio_out_msg #(
	parameter int ID_W = 8
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Load side
	input wire logic load_i,
	input wire logic [cio_pkg::MSG_W-1:0] type_i,
	input wire logic [ID_W-1:0] dest_i,
	input wire logic [ID_W-1:0] sec_i,
	input wire logic data_i,
	// Fabric side
	input wire logic ready_i,
	output logic valid_o,
	output logic [cio_pkg::MSG_W-1:0] type_o,
	output logic [ID_W-1:0] dest_o,
	output logic [ID_W-1:0] sec_o,
	output logic data_o
);

	logic valid_next;
	logic [cio_pkg::MSG_W-1:0] type_next;
	logic [ID_W-1:0] dest_next;
	logic [ID_W-1:0] sec_next;
	logic data_next;

	always_comb begin
		valid_next = valid_o;
		type_next = type_o;
		dest_next = dest_o;
		sec_next = sec_o;
		data_next = data_o;
		if (load_i) begin
			valid_next = 1'b1;
			type_next = type_i;
			dest_next = dest_i;
			sec_next = sec_i;
			data_next = data_i;
		end else if (valid_o && ready_i) begin
			valid_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			valid_o <= 1'b0;
			type_o <= cio_pkg::MSG_DONE;
			dest_o <= '0;
			sec_o <= '0;
			data_o <= 1'b0;
		end else begin
			valid_o <= valid_next;
			type_o <= type_next;
			dest_o <= dest_next;
			sec_o <= sec_next;
			data_o <= data_next;
		end
	end

endmodule

/* src/cio_pkg.sv */
// Shared codes for the coherent I/O read responder
// What this block does
// RL1: The element never starts a coherent I/O read itself, only services incoming ones; with ORIGINATOR_EN set the code does start them (RL2).
// RL2: Originating coherent I/O reads is an option for multi-domain systems.
// RL3: Requests colliding with an outstanding transaction go to collision handling instead.
// RL4: Home dirty locally: fetch newest local copy, after push send DONE with data.
// RL5: Home clean or remote shared: DONE with memory data at once, directory untouched.
// RL6: Dirty at remote owner: forward fetch-from-owner carrying requester as secondary id.
// RL7: Fetch-from-owner received: query own caches repeatedly until a valid answer.
// RL8: Modified line: wait for the processor push before any reply.
// RL9: Modified: sender is secondary gives owner reply with data, else payload then owner reply.
// RL10: Invalid line: reply ownership absent to sender, free entry; other answers are errors.
// RL11: Owner reply at home: update memory, send third-party completion to requester.
// RL12: Absent or retry with line home: payload with memory data, then completion.
// RL13: Absent or retry, still remote dirty: reissue fetch-from-owner to responder, else error.
// RL14: Home fetch finds newest copy without changing any cache coherence state.
// RL15: Protocol errors set a sticky flag and record the offending identity.
package cio_pkg;

	// ------------------------------------------------------------
	// Field widths
	// ------------------------------------------------------------
	localparam int MSG_W = 3;
	localparam int DIR_W = 3;
	localparam int REQ_W = 2;
	localparam int CRSP_W = 2;
	localparam int ERR_W = 3;

	// ------------------------------------------------------------
	// Incoming request kinds
	// ------------------------------------------------------------
	localparam logic [REQ_W-1:0] REQ_FETCH_TO_HOME = 2'h0;
	localparam logic [REQ_W-1:0] REQ_FETCH_FROM_OWNER = 2'h1;

	// ------------------------------------------------------------
	// Directory states
	// ------------------------------------------------------------
	localparam logic [DIR_W-1:0] DIR_CLEAN_HOME = 3'h0;
	localparam logic [DIR_W-1:0] DIR_DIRTY_HOME = 3'h1;
	localparam logic [DIR_W-1:0] DIR_REMOTE_SHARED = 3'h2;
	localparam logic [DIR_W-1:0] DIR_DIRTY_REMOTE = 3'h3;

	// ------------------------------------------------------------
	// Local cache answers
	// ------------------------------------------------------------
	localparam logic [CRSP_W-1:0] CRSP_NOT_READY = 2'h0;
	localparam logic [CRSP_W-1:0] CRSP_MODIFIED = 2'h1;
	localparam logic [CRSP_W-1:0] CRSP_INVALID = 2'h2;
	localparam logic [CRSP_W-1:0] CRSP_SHARED = 2'h3;

	// ------------------------------------------------------------
	// Message kinds, both directions
	// ------------------------------------------------------------
	localparam logic [MSG_W-1:0] MSG_DONE = 3'h0;
	localparam logic [MSG_W-1:0] MSG_FETCH_FROM_OWNER = 3'h1;
	localparam logic [MSG_W-1:0] MSG_OWNER_SUPPLIED = 3'h2;
	localparam logic [MSG_W-1:0] MSG_PAYLOAD_ONLY = 3'h3;
	localparam logic [MSG_W-1:0] MSG_OWNERSHIP_ABSENT = 3'h4;
	localparam logic [MSG_W-1:0] MSG_COMPLETION_3P = 3'h5;
	localparam logic [MSG_W-1:0] MSG_FETCH_TO_HOME = 3'h6;
	localparam logic [MSG_W-1:0] MSG_RETRY = 3'h7;

	// ------------------------------------------------------------
	// Error causes
	// ------------------------------------------------------------
	localparam logic [ERR_W-1:0] ERR_NONE = 3'h0;
	localparam logic [ERR_W-1:0] ERR_DIR = 3'h1;
	localparam logic [ERR_W-1:0] ERR_CACHE = 3'h2;
	localparam logic [ERR_W-1:0] ERR_RSP = 3'h3;
	localparam logic [ERR_W-1:0] ERR_REQ = 3'h4;

endpackage

/* src/coherent_io_read_home_responder.sv */
// Coherent I/O read home and owner responder
`timescale 1ns/10ps
module coherent_io_read_home_responder #(
	parameter int ID_W = 8,
	parameter bit ORIGINATOR_EN = 1'b0
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Incoming requests
	input wire logic req_valid_i,
	input wire logic [cio_pkg::REQ_W-1:0] req_type_i,
	input wire logic [ID_W-1:0] req_src_i,
	input wire logic [ID_W-1:0] req_sec_i,
	input wire logic req_collide_i,
	output logic req_ready_o,
	output logic collide_o,
	// Directory view of the addressed line
	input wire logic [cio_pkg::DIR_W-1:0] dir_state_i,
	input wire logic [ID_W-1:0] owner_node_id_i,
	// Incoming responses
	input wire logic rsp_valid_i,
	input wire logic [cio_pkg::MSG_W-1:0] rsp_type_i,
	input wire logic [ID_W-1:0] rsp_src_i,
	// Local caches and processor push
	output logic cache_req_o,
	input wire logic cache_rsp_valid_i,
	input wire logic [cio_pkg::CRSP_W-1:0] cache_rsp_i,
	input wire logic push_done_i,
	// Memory update
	output logic mem_write_o,
	// Outbound messages
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [cio_pkg::MSG_W-1:0] out_type_o,
	output logic [ID_W-1:0] out_dest_o,
	output logic [ID_W-1:0] out_sec_o,
	output logic out_data_o,
	// Optional local originator
	input wire logic orig_req_i,
	input wire logic [ID_W-1:0] orig_home_i,
	output logic orig_done_o,
	// Error reporting
	input wire logic err_clear_i,
	output logic err_o,
	output logic [ID_W-1:0] err_id_o,
	output logic [cio_pkg::ERR_W-1:0] err_cause_o
);

	// ------------------------------------------------------------
	// Entry state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		S_IDLE,
		S_HOME_PUSH,
		S_OWNER_WAIT,
		S_OWN_FETCH,
		S_OWN_PUSH,
		S_EMIT,
		S_ORIG_WAIT
	} state_t;

	state_t state_reg, state_next, after_reg, after_next;
	logic [ID_W-1:0] src_reg, src_next, sec_reg, sec_next;
	logic [cio_pkg::MSG_W-1:0] pend_type_reg, pend_type_next, p2_type_reg, p2_type_next;
	logic [ID_W-1:0] pend_dest_reg, pend_dest_next, p2_dest_reg, p2_dest_next;
	logic [ID_W-1:0] pend_sec_reg, pend_sec_next;
	logic pend_data_reg, pend_data_next, p2_data_reg, p2_data_next;
	logic p2_valid_reg, p2_valid_next;
	logic req_ready_reg, req_ready_next;
	logic cache_req_reg, cache_req_next;
	logic mem_write_reg, mem_write_next;
	logic collide_reg, collide_next;
	logic orig_done_reg, orig_done_next;
	logic load;
	logic err_set;
	logic [ID_W-1:0] err_id;
	logic [cio_pkg::ERR_W-1:0] err_cause;
	logic accept;

	assign accept = req_valid_i && req_ready_reg;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		after_next = after_reg;
		src_next = src_reg;
		sec_next = sec_reg;
		pend_type_next = pend_type_reg;
		pend_dest_next = pend_dest_reg;
		pend_sec_next = pend_sec_reg;
		pend_data_next = pend_data_reg;
		p2_type_next = p2_type_reg;
		p2_dest_next = p2_dest_reg;
		p2_data_next = p2_data_reg;
		p2_valid_next = p2_valid_reg;
		cache_req_next = 1'b0;
		mem_write_next = 1'b0;
		collide_next = 1'b0;
		orig_done_next = 1'b0;
		load = 1'b0;
		err_set = 1'b0;
		err_id = src_reg;
		err_cause = cio_pkg::ERR_NONE;
		case (state_reg)
			S_IDLE: begin
				if (accept) begin
					src_next = req_src_i;
					sec_next = req_sec_i;
					err_id = req_src_i;
					if (req_collide_i) begin
						collide_next = 1'b1; // [RL3]
					end else if (req_type_i == cio_pkg::REQ_FETCH_TO_HOME) begin
						sec_next = req_src_i;
						case (dir_state_i)
							cio_pkg::DIR_DIRTY_HOME: begin
								// Read-latest leaves cache states as they are [RL14]
								cache_req_next = 1'b1; // [RL4]
								state_next = S_HOME_PUSH;
							end
							cio_pkg::DIR_CLEAN_HOME, cio_pkg::DIR_REMOTE_SHARED: begin
								pend_type_next = cio_pkg::MSG_DONE; // [RL5]
								pend_dest_next = req_src_i;
								pend_sec_next = '0;
								pend_data_next = 1'b1;
								after_next = S_IDLE;
								state_next = S_EMIT;
							end
							cio_pkg::DIR_DIRTY_REMOTE: begin
								pend_type_next = cio_pkg::MSG_FETCH_FROM_OWNER; // [RL6]
								pend_dest_next = owner_node_id_i;
								pend_sec_next = req_src_i;
								pend_data_next = 1'b0;
								after_next = S_OWNER_WAIT;
								state_next = S_EMIT;
							end
							default: begin
								err_set = 1'b1; // [RL15]
								err_cause = cio_pkg::ERR_DIR;
							end
						endcase
					end else if (req_type_i == cio_pkg::REQ_FETCH_FROM_OWNER) begin
						cache_req_next = 1'b1; // [RL7]
						state_next = S_OWN_FETCH;
					end else begin
						err_set = 1'b1; // [RL15]
						err_cause = cio_pkg::ERR_REQ;
					end
				end else if (ORIGINATOR_EN && orig_req_i && req_ready_reg) begin
					pend_type_next = cio_pkg::MSG_FETCH_TO_HOME; // [RL1] [RL2]
					pend_dest_next = orig_home_i;
					pend_sec_next = '0;
					pend_data_next = 1'b0;
					src_next = orig_home_i;
					after_next = S_ORIG_WAIT;
					state_next = S_EMIT;
				end
			end
			S_HOME_PUSH: begin
				if (push_done_i) begin
					pend_type_next = cio_pkg::MSG_DONE; // [RL4]
					pend_dest_next = src_reg;
					pend_sec_next = '0;
					pend_data_next = 1'b1;
					after_next = S_IDLE;
					state_next = S_EMIT;
				end
			end
			S_OWN_FETCH: begin
				if (cache_rsp_valid_i) begin
					case (cache_rsp_i)
						cio_pkg::CRSP_NOT_READY: cache_req_next = 1'b1; // [RL7]
						cio_pkg::CRSP_MODIFIED: state_next = S_OWN_PUSH; // [RL8]
						cio_pkg::CRSP_INVALID: begin
							pend_type_next = cio_pkg::MSG_OWNERSHIP_ABSENT; // [RL10]
							pend_dest_next = src_reg;
							pend_sec_next = '0;
							pend_data_next = 1'b0;
							after_next = S_IDLE;
							state_next = S_EMIT;
						end
						default: begin
							err_set = 1'b1; // [RL10] [RL15]
							err_cause = cio_pkg::ERR_CACHE;
							state_next = S_IDLE;
						end
					endcase
				end
			end
			S_OWN_PUSH: begin
				if (push_done_i) begin // [RL8]
					pend_sec_next = '0;
					pend_data_next = 1'b1;
					after_next = S_IDLE;
					state_next = S_EMIT;
					if (src_reg == sec_reg) begin
						pend_type_next = cio_pkg::MSG_OWNER_SUPPLIED; // [RL9]
						pend_dest_next = src_reg;
					end else begin
						pend_type_next = cio_pkg::MSG_PAYLOAD_ONLY; // [RL9]
						pend_dest_next = sec_reg;
						p2_type_next = cio_pkg::MSG_OWNER_SUPPLIED;
						p2_dest_next = src_reg;
						p2_data_next = 1'b0;
						p2_valid_next = 1'b1;
					end
				end
			end
			S_OWNER_WAIT: begin
				if (rsp_valid_i) begin
					err_id = rsp_src_i;
					pend_sec_next = '0;
					if (rsp_type_i == cio_pkg::MSG_OWNER_SUPPLIED) begin
						mem_write_next = 1'b1; // [RL11]
						pend_type_next = cio_pkg::MSG_COMPLETION_3P;
						pend_dest_next = sec_reg;
						pend_data_next = 1'b0;
						after_next = S_IDLE;
						state_next = S_EMIT;
					end else if (rsp_type_i == cio_pkg::MSG_OWNERSHIP_ABSENT ||
						rsp_type_i == cio_pkg::MSG_RETRY) begin
						case (dir_state_i)
							cio_pkg::DIR_DIRTY_HOME, cio_pkg::DIR_CLEAN_HOME: begin
								pend_type_next = cio_pkg::MSG_PAYLOAD_ONLY; // [RL12]
								pend_dest_next = sec_reg;
								pend_data_next = 1'b1;
								p2_type_next = cio_pkg::MSG_COMPLETION_3P;
								p2_dest_next = sec_reg;
								p2_data_next = 1'b0;
								p2_valid_next = 1'b1;
								after_next = S_IDLE;
								state_next = S_EMIT;
							end
							cio_pkg::DIR_DIRTY_REMOTE: begin
								pend_type_next = cio_pkg::MSG_FETCH_FROM_OWNER; // [RL13]
								pend_dest_next = rsp_src_i;
								pend_sec_next = sec_reg;
								pend_data_next = 1'b0;
								after_next = S_OWNER_WAIT;
								state_next = S_EMIT;
							end
							default: begin
								err_set = 1'b1; // [RL13] [RL15]
								err_cause = cio_pkg::ERR_DIR;
								state_next = S_IDLE;
							end
						endcase
					end else begin
						err_set = 1'b1; // [RL13] [RL15]
						err_cause = cio_pkg::ERR_RSP;
						state_next = S_IDLE;
					end
				end
			end
			S_ORIG_WAIT: begin
				if (rsp_valid_i) begin
					err_id = rsp_src_i;
					if (rsp_type_i == cio_pkg::MSG_DONE) begin
						orig_done_next = 1'b1; // [RL2]
						state_next = S_IDLE;
					end else if (rsp_type_i == cio_pkg::MSG_RETRY) begin
						pend_dest_next = rsp_src_i; // [RL2]
						after_next = S_ORIG_WAIT;
						state_next = S_EMIT;
					end else begin
						err_set = 1'b1; // [RL15]
						err_cause = cio_pkg::ERR_RSP;
						state_next = S_IDLE;
					end
				end
			end
			S_EMIT: begin
				if (!out_valid_o) begin
					load = 1'b1;
					if (p2_valid_reg) begin
						pend_type_next = p2_type_reg;
						pend_dest_next = p2_dest_reg;
						pend_data_next = p2_data_reg;
						pend_sec_next = '0;
						p2_valid_next = 1'b0;
					end else begin
						state_next = after_reg;
					end
				end
			end
			default: state_next = S_IDLE;
		endcase
		// Stray response while none is awaited
		if (rsp_valid_i && state_reg != S_OWNER_WAIT && state_reg != S_ORIG_WAIT) begin
			err_set = 1'b1; // [RL15]
			err_cause = cio_pkg::ERR_RSP;
			err_id = rsp_src_i;
		end
		req_ready_next = (state_next == S_IDLE) && !load && !(out_valid_o && !out_ready_i);
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			state_reg <= S_IDLE;
			after_reg <= S_IDLE;
			src_reg <= '0;
			sec_reg <= '0;
			pend_type_reg <= cio_pkg::MSG_DONE;
			pend_dest_reg <= '0;
			pend_sec_reg <= '0;
			pend_data_reg <= 1'b0;
			p2_type_reg <= cio_pkg::MSG_DONE;
			p2_dest_reg <= '0;
			p2_data_reg <= 1'b0;
			p2_valid_reg <= 1'b0;
			req_ready_reg <= 1'b0;
			cache_req_reg <= 1'b0;
			mem_write_reg <= 1'b0;
			collide_reg <= 1'b0;
			orig_done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			after_reg <= after_next;
			src_reg <= src_next;
			sec_reg <= sec_next;
			pend_type_reg <= pend_type_next;
			pend_dest_reg <= pend_dest_next;
			pend_sec_reg <= pend_sec_next;
			pend_data_reg <= pend_data_next;
			p2_type_reg <= p2_type_next;
			p2_dest_reg <= p2_dest_next;
			p2_data_reg <= p2_data_next;
			p2_valid_reg <= p2_valid_next;
			req_ready_reg <= req_ready_next;
			cache_req_reg <= cache_req_next;
			mem_write_reg <= mem_write_next;
			collide_reg <= collide_next;
			orig_done_reg <= orig_done_next;
		end
	end

	assign req_ready_o = req_ready_reg;
	assign cache_req_o = cache_req_reg;
	assign mem_write_o = mem_write_reg;
	assign collide_o = collide_reg;
	assign orig_done_o = orig_done_reg;

	// ------------------------------------------------------------
	// Outbound message slot and error record
	// ------------------------------------------------------------
	cio_out_msg #(.ID_W(ID_W)) u_out (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.load_i(load),
		.type_i(pend_type_reg),
		.dest_i(pend_dest_reg),
		.sec_i(pend_sec_reg),
		.data_i(pend_data_reg),
		.ready_i(out_ready_i),
		.valid_o(out_valid_o),
		.type_o(out_type_o),
		.dest_o(out_dest_o),
		.sec_o(out_sec_o),
		.data_o(out_data_o)
	);

	cio_err_latch #(.ID_W(ID_W)) u_err (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.set_i(err_set),
		.id_i(err_id),
		.cause_i(err_cause),
		.clear_i(err_clear_i),
		.flag_o(err_o),
		.id_o(err_id_o),
		.cause_o(err_cause_o)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence seq_home_req(logic [cio_pkg::DIR_W-1:0] d);
		accept && !req_collide_i && req_type_i == cio_pkg::REQ_FETCH_TO_HOME && dir_state_i == d;
	endsequence

	sequence seq_owner_invalid;
		state_reg == S_OWN_FETCH && cache_rsp_valid_i && cache_rsp_i == cio_pkg::CRSP_INVALID;
	endsequence

	a_no_originate: assert property (out_valid_o && !ORIGINATOR_EN |-> out_type_o != cio_pkg::MSG_FETCH_TO_HOME) else $error("fetch to home originated"); // [RL1]
	a_collide_route: assert property (accept && req_collide_i |=> collide_o && !cache_req_o && !out_valid_o) else $error("collision not routed"); // [RL3]
	a_dirty_fetch: assert property (seq_home_req(cio_pkg::DIR_DIRTY_HOME) |=> cache_req_o) else $error("no local fetch for dirty home"); // [RL4]
	a_push_hold: assert property (state_reg == S_HOME_PUSH || state_reg == S_OWN_PUSH |-> !out_valid_o) else $error("reply before push"); // [RL8]
	a_clean_done: assert property (seq_home_req(cio_pkg::DIR_CLEAN_HOME) |-> ##2 out_valid_o && out_type_o == cio_pkg::MSG_DONE && out_data_o && out_dest_o == $past(req_src_i, 2)) else $error("clean done wrong"); // [RL5]
	a_owner_fwd: assert property (seq_home_req(cio_pkg::DIR_DIRTY_REMOTE) |-> ##2 out_valid_o && out_type_o == cio_pkg::MSG_FETCH_FROM_OWNER && out_dest_o == $past(owner_node_id_i, 2) && out_sec_o == $past(req_src_i, 2)) else $error("owner forward wrong"); // [RL6]
	a_cache_retry: assert property (state_reg == S_OWN_FETCH && cache_rsp_valid_i && cache_rsp_i == cio_pkg::CRSP_NOT_READY |=> cache_req_o) else $error("local fetch not repeated"); // [RL7]
	a_absent_reply: assert property (seq_owner_invalid |-> ##2 out_valid_o && out_type_o == cio_pkg::MSG_OWNERSHIP_ABSENT && out_dest_o == src_reg) else $error("absent reply wrong"); // [RL10]
	a_mem_update: assert property (state_reg == S_OWNER_WAIT && rsp_valid_i && rsp_type_i == cio_pkg::MSG_OWNER_SUPPLIED |=> mem_write_o ##1 (out_valid_o && out_type_o == cio_pkg::MSG_COMPLETION_3P)) else $error("owner reply not handled"); // [RL11]
	a_error_sticky: assert property (err_o && !err_clear_i |=> err_o) else $error("error flag dropped"); // [RL15]

endmodule
